// ### rtl/settle_timer.sv
// Reference stabilization timer for the supply trip detector
`timescale 1ns/100ps
module settle_timer #(
  parameter int CYCLES = trip_detect_pkg::REF_SETTLE_CYCLES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_enable,
  output logic      o_stable,
  output logic      o_settled
);
  import trip_detect_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count_r;

  // Counts enabled cycles, restarts whenever enable drops
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !i_enable) begin
      count_r <= '0;
    end else if (!o_stable) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  // Stable once the whole interval has passed
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !i_enable) begin
      o_stable <= 1'b0;
    end else if (count_r == LAST) begin
      o_stable <= 1'b1;
    end
  end

  // One-cycle pulse when stability is reached
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_settled <= 1'b0;
    end else begin
      o_settled <= i_enable && !o_stable && (count_r == LAST);
    end
  end

endmodule // settle_timer

// ### rtl/supply_trip_detector.sv
// Digital control and event logic of the supply trip detector
`timescale 1ns/100ps
module supply_trip_detector #(
  parameter int SETTLE_CYCLES = trip_detect_pkg::REF_SETTLE_CYCLES,
  parameter int TAPS          = trip_detect_pkg::NUM_TAPS
) (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_reset_n,
  // Register port
  input  wire logic [trip_detect_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [trip_detect_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  output logic      [trip_detect_pkg::DATA_W-1:0]  o_rdata,
  // Analogue comparator side
  input  wire logic                                i_supply_above_level,
  output logic                                     o_detector_power,
  output logic      [TAPS-1:0]                     o_tap_select,
  output logic                                     o_external_select,
  output logic                                     o_trip_direction,
  // Event side
  output logic                                     o_event_flag,
  output logic                                     o_wake_request,
  output logic                                     o_irq
);
  import trip_detect_pkg::*;

  // Control register fields
  logic               dir_r;
  logic               enable_r;
  logic [LEVEL_W-1:0] level_r;

  // Flag and mask registers
  logic               volt_flag_r;
  logic               volt_flag_nxt;
  logic               settle_flag_r;
  logic               settle_flag_nxt;
  logic               volt_mask_r;
  logic               settle_mask_r;
  logic               volt_mask_nxt;
  logic               settle_mask_nxt;
  logic               volt_clr;
  logic               settle_clr;

  // Register views as software reads them
  logic [DATA_W-1:0]  ctrl_view;
  logic [DATA_W-1:0]  flag_view;
  logic [DATA_W-1:0]  mask_view;
  logic [DATA_W-1:0]  live_view;

  // Timer outputs
  logic               stable;
  logic               settled;

  // Decoded accesses
  logic               wr_ctrl;
  logic               wr_flag;
  logic               wr_mask;
  logic               hit;
  logic               level_is_ext;

  // Event terms
  logic               crossing;
  logic               detector_live;
  logic               volt_event;

  // Output flops
  logic [DATA_W-1:0]  rdata_r;
  logic [DATA_W-1:0]  rdata_nxt;
  logic [TAPS-1:0]    tap_r;
  logic [TAPS-1:0]    tap_nxt;
  logic               ext_sel_r;
  logic               power_r;
  logic               direction_r;
  logic               irq_r;
  logic               wake_r;
  logic               irq_nxt;

  // Address decode of write strobes and of the register hit
  assign wr_ctrl = i_wr && (i_addr == CTRL_OFFSET);
  assign wr_flag = i_wr && (i_addr == FLAG_OFFSET);
  assign wr_mask = i_wr && (i_addr == MASK_OFFSET);
  assign hit     = (i_addr == CTRL_OFFSET) || (i_addr == FLAG_OFFSET) ||
                   (i_addr == MASK_OFFSET) || (i_addr == LIVE_OFFSET);

  // Top level code hands the comparator to the external pin
  assign level_is_ext = (level_r == LEVEL_EXTERNAL);

  // Direction select field
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      dir_r <= DIR_RESET;
    end else if (wr_ctrl) begin
      dir_r <= i_wdata[DIR_BIT];
    end
  end

  // Power enable field
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      enable_r <= EN_RESET;
    end else if (wr_ctrl) begin
      enable_r <= i_wdata[ENABLE_BIT];
    end
  end

  // Trip level field
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      level_r <= LEVEL_RESET;
    end else if (wr_ctrl) begin
      level_r <= i_wdata[LEVEL_LSB +: LEVEL_W];
    end
  end

  // Stabilization tracking, restarted on every enable
  settle_timer #(
    .CYCLES    (SETTLE_CYCLES)
  ) u_settle (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (enable_r),
    .o_stable  (stable),
    .o_settled (settled)
  );

  // Comparator result in the selected direction
  always_comb begin
    if (dir_r) begin
      crossing = i_supply_above_level;
    end else begin
      crossing = !i_supply_above_level;
    end
  end

  // Detector is live once enabled and settled
  assign detector_live = enable_r && stable;

  // Only a live detector raises an event
  assign volt_event = detector_live && crossing;

  // Write-one clears of the sticky flags
  assign volt_clr   = wr_flag && i_wdata[VOLT_EVT_BIT];
  assign settle_clr = wr_flag && i_wdata[SETTLE_EVT_BIT];

  // Voltage event flag, set wins over a write-one clear
  always_comb begin
    volt_flag_nxt = volt_flag_r;
    if (volt_clr) begin
      volt_flag_nxt = 1'b0;
    end
    if (volt_event) begin
      volt_flag_nxt = 1'b1;
    end
  end

  // Settle event flag, set wins over a write-one clear
  always_comb begin
    settle_flag_nxt = settle_flag_r;
    if (settle_clr) begin
      settle_flag_nxt = 1'b0;
    end
    if (settled) begin
      settle_flag_nxt = 1'b1;
    end
  end

  // Voltage event flag register, sticky until cleared
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      volt_flag_r <= 1'b0;
    end else begin
      volt_flag_r <= volt_flag_nxt;
    end
  end

  // Settle event flag register, sticky until cleared
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      settle_flag_r <= 1'b0;
    end else begin
      settle_flag_r <= settle_flag_nxt;
    end
  end

  // Mask next values, loaded by a mask write
  always_comb begin
    volt_mask_nxt   = volt_mask_r;
    settle_mask_nxt = settle_mask_r;
    if (wr_mask) begin
      volt_mask_nxt   = i_wdata[VOLT_EVT_BIT];
      settle_mask_nxt = i_wdata[SETTLE_EVT_BIT];
    end
  end

  // Voltage event mask bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      volt_mask_r <= MASK_RESET[VOLT_EVT_BIT];
    end else begin
      volt_mask_r <= volt_mask_nxt;
    end
  end

  // Settle event mask bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      settle_mask_r <= MASK_RESET[SETTLE_EVT_BIT];
    end else begin
      settle_mask_r <= settle_mask_nxt;
    end
  end

  // Control register as read back, bit 6 unimplemented
  always_comb begin
    ctrl_view                        = '0;
    ctrl_view[DIR_BIT]               = dir_r;
    ctrl_view[RSVD_BIT]              = 1'b0;
    ctrl_view[STABLE_BIT]            = stable;
    ctrl_view[ENABLE_BIT]            = enable_r;
    ctrl_view[LEVEL_LSB +: LEVEL_W]  = level_r;
  end

  // Flag register as read back, unused bits zero
  always_comb begin
    flag_view                  = '0;
    flag_view[VOLT_EVT_BIT]    = volt_flag_r;
    flag_view[SETTLE_EVT_BIT]  = settle_flag_r;
  end

  // Mask register as read back, same layout as the flags
  always_comb begin
    mask_view                  = '0;
    mask_view[VOLT_EVT_BIT]    = volt_mask_r;
    mask_view[SETTLE_EVT_BIT]  = settle_mask_r;
  end

  // Live comparator state for polling software
  always_comb begin
    live_view                  = '0;
    live_view[LIVE_CMP_BIT]    = i_supply_above_level;
    live_view[LIVE_CROSS_BIT]  = volt_event;
  end

  // Read mux, unmapped addresses and idle cycles give zero
  always_comb begin
    rdata_nxt = '0;
    if (i_rd && hit) begin
      case (i_addr)
        CTRL_OFFSET: begin
          rdata_nxt = ctrl_view;
        end
        FLAG_OFFSET: begin
          rdata_nxt = flag_view;
        end
        MASK_OFFSET: begin
          rdata_nxt = mask_view;
        end
        LIVE_OFFSET: begin
          rdata_nxt = live_view;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // One-hot divider tap select, code i picks tap i
  generate
    for (genvar i = 0; i < TAPS; i++) begin : g_tap
      assign tap_nxt[i] = enable_r && (level_r == LEVEL_W'(i));
      always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
          tap_r[i] <= 1'b0;
        end else begin
          tap_r[i] <= tap_nxt[i];
        end
      end
    end
  endgenerate

  // External input replaces the divider on the top code
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ext_sel_r <= 1'b0;
    end else begin
      ext_sel_r <= enable_r && level_is_ext;
    end
  end

  // Analogue power drive follows the enable bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      power_r <= 1'b0;
    end else begin
      power_r <= enable_r;
    end
  end

  // Direction drive to the comparator
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      direction_r <= DIR_RESET;
    end else begin
      direction_r <= dir_r;
    end
  end

  // Unmasked sticky flags, in step with the flag and mask registers
  assign irq_nxt = (volt_flag_nxt && volt_mask_nxt) ||
                   (settle_flag_nxt && settle_mask_nxt);

  // Level interrupt from unmasked sticky flags
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Wake request follows the voltage event flag, also asleep
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= volt_flag_nxt;
    end
  end

  // Outputs straight from flops
  assign o_rdata           = rdata_r;
  assign o_tap_select      = tap_r;
  assign o_external_select = ext_sel_r;
  assign o_detector_power  = power_r;
  assign o_trip_direction  = direction_r;
  assign o_event_flag      = volt_flag_r;
  assign o_wake_request    = wake_r;
  assign o_irq             = irq_r;

endmodule // supply_trip_detector

// ### rtl/trip_detect_pkg.sv
// Constants shared by the supply trip detector design
//
// Behaviour
// - Detector circuitry active only while enable set
// - Each enable rise starts a stabilization interval
// - Read-only stable flag at control bit 5
// - No voltage event before stable flag set
// - Bit 7 selects fall-below or rise-above detection
// - Crossing in selected direction sets event flag
// - Bits 3..0 select one of 16 levels
// - Code 1111 routes external input to comparator
// - No event until settle interval has expired
// - Event flag at flag register bit 2
// - Detector runs in sleep, crossing wakes device
// - Reset returns control register, detector off
package trip_detect_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] FLAG_OFFSET = 8'h01;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 8'h02;
  localparam logic [ADDR_W-1:0] LIVE_OFFSET = 8'h03;

  // Control register field positions
  localparam int DIR_BIT    = 7;
  localparam int RSVD_BIT   = 6;
  localparam int STABLE_BIT = 5;
  localparam int ENABLE_BIT = 4;
  localparam int LEVEL_LSB  = 0;
  localparam int LEVEL_W    = 4;

  // Flag and mask register field positions
  localparam int VOLT_EVT_BIT   = 2;
  localparam int SETTLE_EVT_BIT = 0;

  // Live state register field positions
  localparam int LIVE_CMP_BIT   = 0;
  localparam int LIVE_CROSS_BIT = 1;

  // Reset values
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h5;
  localparam logic               DIR_RESET   = 1'b0;
  localparam logic               EN_RESET    = 1'b0;
  localparam logic [DATA_W-1:0]  MASK_RESET  = 8'h00;

  // Trip level codes
  localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hf;
  localparam int                 NUM_TAPS       = 15;

  // Reference settle time and its cycle count at 250 MHz
  localparam int CLK_PERIOD_PS         = 4000;
  localparam int REF_SETTLE_TIME_NS    = 10000;
  localparam int REF_SETTLE_CYCLES     =
    (REF_SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ### testbench/supply_trip_detector_tb_top.sv
// Self-checking bench for the supply trip detector
`timescale 1ns/100ps
module supply_trip_detector_tb_top;
  import trip_detect_pkg::*;
  localparam int S = 8;
  logic        i_sys_clk, i_reset_n, i_wr, i_rd, i_supply_above_level;
  logic [7:0]  i_addr, i_wdata, o_rdata, w;
  logic [14:0] o_tap_select;
  logic        o_detector_power, o_external_select, o_trip_direction;
  logic        o_event_flag, o_wake_request, o_irq;
  int          bad_count, comparisons, n;

  supply_trip_detector #(.SETTLE_CYCLES(S)) dut (.i_sys_clk, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_supply_above_level, .o_detector_power,
    .o_tap_select, .o_external_select, .o_trip_direction, .o_event_flag,
    .o_wake_request, .o_irq);

  // 250 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [14:0] exp_taps(input logic [7:0] c);
    exp_taps = '0;
    if (c[4] && c[3:0] != 4'hf) exp_taps[c[3:0]] = 1'b1;
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected pins at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Register write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  // Register read and compare; data stand the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    comparisons++;
    if (o_rdata !== e) begin
      bad_count++;
      $display("unexpected read at %0t: addr %h got %h want %h", $time, a, o_rdata, e);
    end
  endtask

  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask

  // Enable with falling-supply detection and time the first event
  task automatic settle_chk();
    wr(CTRL_OFFSET, 8'h13);
    n = 0;
    while (o_event_flag !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk_pin(16'(n), 16'(S + 1));
    if (n >= 100) conclude();
    chk_pin({14'h0, o_irq, o_wake_request}, 16'h3);
  endtask

  initial begin
    i_reset_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_supply_above_level = 1'b1;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(49));
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_pin({o_tap_select, o_irq}, 16'h0);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rdc(CTRL_OFFSET, 8'h05);
    rdc(FLAG_OFFSET, 8'h00);
    // Every level code with random direction, reserved bits and supply
    for (int c = 0; c < 16; c++) begin
      w = 8'($urandom());
      w[4] = 1'b1;
      w[3:0] = 4'(c);
      @(posedge i_sys_clk);
      i_supply_above_level <= w[6];
      wr(CTRL_OFFSET, w);
      step();
      chk_pin({1'b0, o_tap_select}, {1'b0, exp_taps(w)});
      chk_pin({13'h0, o_external_select, o_trip_direction, o_detector_power},
              {13'h0, w[3:0] == 4'hf, w[7], 1'b1});
    end
    rdc(CTRL_OFFSET, {w[7], 2'b01, w[4:0]});
    wr(CTRL_OFFSET, 8'h6a);
    step();
    chk_pin({o_tap_select, o_detector_power}, 16'h0);
    rdc(CTRL_OFFSET, 8'h0a);
    wr(FLAG_OFFSET, 8'h05);
    rdc(FLAG_OFFSET, 8'h00);
    wr(MASK_OFFSET, 8'h04);
    @(posedge i_sys_clk);
    i_supply_above_level <= 1'b0;
    settle_chk();
    rdc(CTRL_OFFSET, 8'h33);
    rdc(FLAG_OFFSET, 8'h05);
    rdc(LIVE_OFFSET, 8'h02);
    rdc(MASK_OFFSET, 8'h04);
    // Clearing while the condition holds loses to the new event
    wr(FLAG_OFFSET, 8'h04);
    step();
    chk_pin({15'h0, o_event_flag}, 16'h1);
    @(posedge i_sys_clk);
    i_supply_above_level <= 1'b1;
    wr(FLAG_OFFSET, 8'h05);
    step();
    chk_pin({14'h0, o_event_flag, o_irq}, 16'h0);
    // Rising detection with the event masked off
    wr(MASK_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h93);
    step();
    step();
    chk_pin({14'h0, o_event_flag, o_irq}, 16'h2);
    @(posedge i_sys_clk);
    i_supply_above_level <= 1'b0;
    wr(FLAG_OFFSET, 8'h05);
    step();
    chk_pin({15'h0, o_event_flag}, 16'h0);
    // Disable drops stability; the next enable settles afresh
    wr(CTRL_OFFSET, 8'h03);
    step();
    rdc(CTRL_OFFSET, 8'h03);
    wr(MASK_OFFSET, 8'h04);
    settle_chk();
    w = 8'($urandom_range(255, 4));
    wr(w, 8'hff);
    rdc(w, 8'h00);
    // Reset in mid-run with an event pending
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    step();
    step();
    chk_pin({o_tap_select, o_event_flag}, 16'h0);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rdc(CTRL_OFFSET, 8'h05);
    conclude();
  end
endmodule // supply_trip_detector_tb_top

// ### testbench/trip_detect_props.sv
// Port-level property checker for the supply trip detector
`timescale 1ns/100ps
module trip_detect_props import trip_detect_pkg::*; #(
  parameter int SETTLE_CYCLES = 8,
  parameter int TAPS          = 15
) (
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_detector_power,
  input wire logic [TAPS-1:0]   o_tap_select,
  input wire logic              o_external_select,
  input wire logic              o_trip_direction,
  input wire logic              o_event_flag,
  input wire logic              o_wake_request,
  input wire logic              o_irq
);
  logic            ctrl_wr;
  logic [TAPS-1:0] tap_exp;
  logic [15:0]     on_cnt_r;
  // Control writes and the tap pattern they should select
  assign ctrl_wr = i_wr && (i_addr == CTRL_OFFSET);
  always_comb begin
    tap_exp = '0;
    if (i_wdata[ENABLE_BIT] && (i_wdata[3:0] != LEVEL_EXTERNAL)) begin
      tap_exp[i_wdata[3:0]] = 1'b1;
    end
  end
  // Cycles the analogue side has been powered without a break
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !o_detector_power) begin
      on_cnt_r <= '0;
    end else if (on_cnt_r != 16'hffff) begin
      on_cnt_r <= on_cnt_r + 16'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_cw;
    ctrl_wr ##1 !ctrl_wr;
  endsequence
  property p_power; s_cw |=> o_detector_power == $past(i_wdata[ENABLE_BIT], 2); endproperty
  property p_tap; s_cw |=> o_tap_select == $past(tap_exp, 2); endproperty
  property p_ext; s_cw |=> o_external_select == ($past(i_wdata[4:0], 2) == 5'h1f); endproperty
  property p_dir; s_cw |=> o_trip_direction == $past(i_wdata[DIR_BIT], 2); endproperty
  property p_rd_fixed;
    i_rd && i_addr == CTRL_OFFSET && !o_detector_power && !$past(o_detector_power)
      |=> o_rdata[6:5] == 2'b00;
  endproperty
  property p_settle; $rose(o_event_flag) |-> on_cnt_r >= SETTLE_CYCLES; endproperty
  property p_wake; $rose(o_event_flag) |-> o_wake_request; endproperty
  property p_clear;
    i_wr && i_addr == FLAG_OFFSET && i_wdata[VOLT_EVT_BIT] && !o_detector_power
      |=> !o_event_flag;
  endproperty
  property p_reset;
    disable iff (1'b0)
    !i_reset_n |=> o_rdata == '0 && !o_irq && !o_event_flag && !o_detector_power;
  endproperty
  property p_rd_idle; !i_rd |=> o_rdata == '0; endproperty
  a_power: assert property (p_power) else $error("power does not follow enable");
  a_tap: assert property (p_tap) else $error("tap select wrong");
  a_ext: assert property (p_ext) else $error("external select wrong");
  a_dir: assert property (p_dir) else $error("direction output wrong");
  a_rd_fixed: assert property (p_rd_fixed) else $error("bit 6 or 5 set");
  a_settle: assert property (p_settle) else $error("event before settle");
  a_wake: assert property (p_wake) else $error("no wake on event");
  a_clear: assert property (p_clear) else $error("flag not cleared");
  a_reset: assert property (p_reset) else $error("outputs not reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle zero");
  c_event: cover property ($rose(o_event_flag));
  c_ext: cover property (o_external_select);
  c_irq: cover property (o_irq);
endmodule // trip_detect_props

bind supply_trip_detector trip_detect_props #(.SETTLE_CYCLES(SETTLE_CYCLES), .TAPS(TAPS))
  u_props (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_detector_power, .o_tap_select, .o_external_select, .o_trip_direction,
  .o_event_flag, .o_wake_request, .o_irq);
